// ---- src/vpb_pkg.sv ----
package vpb_pkg;

  localparam int DW     = 32;
  localparam int QAW    = 3;
  localparam int QDEPTH = 8;
  localparam int PAW    = 2;
  localparam int PF_LEN = 4;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;

  localparam int CTRL_PF_EN  = 0;
  localparam int CTRL_VM_ARB = 2;
  localparam int CTRL_PM_ARB = 4;
  localparam int CTRL_VME_OWNERSHIP_BIT   = 6;
  localparam int CTRL_W      = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  localparam int STAT_RX_CNT   = 0;
  localparam int STAT_TX_CNT   = 4;
  localparam int STAT_PF_CNT   = 8;
  localparam int STAT_VME_OWNERSHIP_BIT_ACK = 12;

  localparam logic [DW-1:0] PF_STRIDE = 32'h0000_0004;

  typedef enum logic [2:0] {
    XM_A16, XM_A24, XM_A32, XM_BLT, XM_MBLT, XM_A64, XM_A40, XM_MD32
  } vpb_xmode_e;

  typedef enum logic [1:0] {ARB_FAIR, ARB_A_FIRST, ARB_B_FIRST} vpb_arb_e;

  typedef enum logic [1:0] {CYC_SINGLE, CYC_RMW, CYC_ADOH} vpb_cyc_e;

  // modes the bridge carries on either bus
  function automatic logic vpb_mode_ok(input logic [2:0] m);
    return (m != XM_A64) && (m != XM_A40) && (m != XM_MD32);
  endfunction : vpb_mode_ok

  function automatic logic vpb_is_block(input logic [2:0] m);
    return (m == XM_BLT) || (m == XM_MBLT);
  endfunction : vpb_is_block

endpackage : vpb_pkg

// ---- src/vpb_arb_if.sv ----
`timescale 1ns/100ps
interface vpb_arb_if;
  logic       req_urg;
  logic       req_a;
  logic       req_b;
  logic [1:0] mode;
  logic       gnt_urg;
  logic       gnt_a;
  logic       gnt_b;
  modport arb  (input req_urg, req_a, req_b, mode, output gnt_urg, gnt_a, gnt_b);
  modport user (output req_urg, req_a, req_b, mode, input gnt_urg, gnt_a, gnt_b);
endinterface : vpb_arb_if

// ---- src/vpb_arbiter.sv ----
`timescale 1ns/100ps
module vpb_arbiter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  vpb_arb_if.arb   bus
);

  logic busy;
  logic pick_a;
  logic last_b;

  always_comb
  begin
    busy = (bus.gnt_urg & bus.req_urg) | (bus.gnt_a & bus.req_a) | (bus.gnt_b & bus.req_b);
    case (bus.mode)
      vpb_pkg::ARB_A_FIRST: pick_a = 1'b1;
      vpb_pkg::ARB_B_FIRST: pick_a = 1'b0;
      default:              pick_a = last_b;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus.gnt_urg <= 1'b0;
      bus.gnt_a   <= 1'b0;
      bus.gnt_b   <= 1'b0;
    end
    else if (ce_i && !busy)
    begin
      bus.gnt_urg <= bus.req_urg;
      bus.gnt_a   <= !bus.req_urg & bus.req_a & (!bus.req_b | pick_a);
      bus.gnt_b   <= !bus.req_urg & bus.req_b & (!bus.req_a | !pick_a);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      last_b <= 1'b0;
    else if (ce_i && (bus.gnt_a || bus.gnt_b))
      last_b <= bus.gnt_b;
  end

  property p_urg_first;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !busy && bus.req_urg |=> bus.gnt_urg && !bus.gnt_a && !bus.gnt_b;
  endproperty
  a_urg_first: assert property (p_urg_first) else $error("urgent request not first");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      bus.gnt_a && bus.req_a |=> bus.gnt_a;
  endproperty
  a_hold: assert property (p_hold) else $error("grant lost before done");

  property p_fair;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !busy && bus.req_a && bus.req_b && !bus.req_urg && bus.mode == vpb_pkg::ARB_FAIR
      ##0 $past(bus.gnt_b) && !$past(bus.gnt_a) && last_b |=> bus.gnt_a;
  endproperty
  a_fair: assert property (p_fair) else $error("fair turn skipped");

endmodule : vpb_arbiter

// ---- src/vpb_bridge.sv ----
`timescale 1ns/100ps
// What this block does
// - VME slave writes posted or coupled per slave image setting.
// - Posted VME write queued in receive queue, acknowledged at once.
// - Coupled VME write acknowledged only after PCI transaction completes.
// - Block read with prefetch enabled starts a prefetched read.
// - Prefetch fills queue by PCI burst; block data served from queue.
// - VME slave accepts all modes except A64, A40, MD32.
// - VME mastership only for target, DMA or interrupt channel.
// - Interrupt channel beats target and DMA; their order configurable.
// - VME master issues all modes except A64, A40, MD32.
// - VME master does RMW and ADOH; retry is no termination.
// - ADOH cycle carries the VME lock command.
// - PCI reads always coupled, completed with VME data.
// - PCI single-cycle writes posted or coupled per target image setting; RMW and ADOH writes coupled.
// - Posted PCI write queued in transmit queue, zero wait ack.
// - Queued PCI writes go to VME independent of PCI master.
// - Special cycles plus ownership give exclusive multi-cycle VME access.
// - PCI mastership for VME slave or DMA channel, configurable priority.
// - DMA and target channel arbitrated fairly for VME master in ARB_FAIR mode (reset value) and value 3; ARB_A_FIRST, ARB_B_FIRST give fixed priority.
// - Granted channel keeps the bus until it is done.
module vpb_bridge (
  input  wire logic                   clock_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   ce_i,
  input  wire logic [3:0]             reg_addr_i,
  input  wire logic [vpb_pkg::DW-1:0] reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [vpb_pkg::DW-1:0] reg_rdata_o,
  input  wire logic                   vs_req_i,
  input  wire logic                   vs_write_i,
  input  wire logic                   vs_posted_i,
  input  wire logic [2:0]             vs_mode_i,
  input  wire logic [vpb_pkg::DW-1:0] vs_addr_i,
  input  wire logic [vpb_pkg::DW-1:0] vs_wdata_i,
  output logic                        vs_ack_o,
  output logic                        vs_err_o,
  output logic      [vpb_pkg::DW-1:0] vs_rdata_o,
  output logic                        pm_req_o,
  output logic                        pm_write_o,
  output logic                        pm_burst_o,
  output logic      [vpb_pkg::DW-1:0] pm_addr_o,
  output logic      [vpb_pkg::DW-1:0] pm_wdata_o,
  input  wire logic                   pm_rvalid_i,
  input  wire logic [vpb_pkg::DW-1:0] pm_rdata_i,
  input  wire logic                   pm_done_i,
  input  wire logic                   pt_req_i,
  input  wire logic                   pt_write_i,
  input  wire logic                   pt_posted_i,
  input  wire logic [1:0]             pt_cycle_i,
  input  wire logic [2:0]             pt_mode_i,
  input  wire logic [vpb_pkg::DW-1:0] pt_addr_i,
  input  wire logic [vpb_pkg::DW-1:0] pt_wdata_i,
  output logic                        pt_ack_o,
  output logic                        pt_err_o,
  output logic      [vpb_pkg::DW-1:0] pt_rdata_o,
  output logic                        vm_req_o,
  output logic                        vm_write_o,
  output logic      [1:0]             vm_cycle_o,
  output logic      [2:0]             vm_mode_o,
  output logic      [vpb_pkg::DW-1:0] vm_addr_o,
  output logic      [vpb_pkg::DW-1:0] vm_wdata_o,
  input  wire logic [vpb_pkg::DW-1:0] vm_rdata_i,
  input  wire logic                   vm_done_i,
  input  wire logic                   vm_retry_i,
  input  wire logic                   irq_vm_req_i,
  output logic                        irq_vm_gnt_o,
  input  wire logic                   dma_vm_req_i,
  output logic                        dma_vm_gnt_o,
  input  wire logic                   dma_pm_req_i,
  output logic                        dma_pm_gnt_o
);

  typedef enum logic [1:0] {VS_IDLE, VS_CPL, VS_FILL} vpb_vs_e;
  typedef enum logic [1:0] {PJ_POST, PJ_CPL, PJ_FILL} vpb_pj_e;
  typedef enum logic       {PT_IDLE, PT_CPL} vpb_pt_e;

  logic                        rst_q1;
  logic                        rst_n;
  logic [vpb_pkg::CTRL_W-1:0]  ctrl;
  logic                        pf_en;
  logic                        vme_ownership_bit;
  logic                        vme_ownership_bit_ack;
  vpb_vs_e                     vs_st;
  vpb_pj_e                     pm_job;
  vpb_pt_e                     pt_st;
  logic [vpb_pkg::DW-1:0]      rx_addr [vpb_pkg::QDEPTH];
  logic [vpb_pkg::DW-1:0]      rx_data [vpb_pkg::QDEPTH];
  logic [vpb_pkg::QAW-1:0]     rx_wp;
  logic [vpb_pkg::QAW-1:0]     rx_rp;
  logic [vpb_pkg::QAW:0]       rx_cnt;
  logic [vpb_pkg::DW-1:0]      tx_addr [vpb_pkg::QDEPTH];
  logic [vpb_pkg::DW-1:0]      tx_data [vpb_pkg::QDEPTH];
  logic [2:0]                  tx_mode [vpb_pkg::QDEPTH];
  logic [vpb_pkg::QAW-1:0]     tx_wp;
  logic [vpb_pkg::QAW-1:0]     tx_rp;
  logic [vpb_pkg::QAW:0]       tx_cnt;
  logic [vpb_pkg::DW-1:0]      pfq [vpb_pkg::PF_LEN];
  logic [vpb_pkg::PAW-1:0]     pf_wp;
  logic [vpb_pkg::PAW-1:0]     pf_rp;
  logic [vpb_pkg::PAW:0]       pf_cnt;
  logic [vpb_pkg::DW-1:0]      pf_addr;
  logic                        vs_take;
  logic                        vs_bad;
  logic                        vs_post;
  logic                        vs_pf;
  logic                        vs_hit;
  logic                        rx_full;
  logic                        rx_push;
  logic                        rx_pop;
  logic                        pf_push;
  logic                        pm_end;
  logic                        pt_take;
  logic                        pt_bad;
  logic                        pt_post;
  logic                        tx_full;
  logic                        tx_push;
  logic                        tx_pop;
  logic                        vm_cpl;
  logic                        vm_end;

  vpb_arb_if pm_arb ();
  vpb_arb_if vm_arb ();

  //////////////////////////////////////////////////////////////////////////////
  // reset release and registers

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  assign pf_en = ctrl[vpb_pkg::CTRL_PF_EN];
  assign vme_ownership_bit  = ctrl[vpb_pkg::CTRL_VME_OWNERSHIP_BIT];

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= vpb_pkg::CTRL_RESET;
    else if (ce_i && reg_wr_i && reg_addr_i == vpb_pkg::REG_CTRL)
      ctrl <= reg_wdata_i[vpb_pkg::CTRL_W-1:0];
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_o <= '0;
    else if (ce_i)
    begin
      reg_rdata_o <= '0;
      if (reg_rd_i && reg_addr_i == vpb_pkg::REG_CTRL)
        reg_rdata_o[vpb_pkg::CTRL_W-1:0] <= ctrl;
      else if (reg_rd_i && reg_addr_i == vpb_pkg::REG_STAT)
      begin
        reg_rdata_o[vpb_pkg::STAT_RX_CNT +: vpb_pkg::QAW+1] <= rx_cnt;
        reg_rdata_o[vpb_pkg::STAT_TX_CNT +: vpb_pkg::QAW+1] <= tx_cnt;
        reg_rdata_o[vpb_pkg::STAT_PF_CNT +: vpb_pkg::PAW+1] <= pf_cnt;
        reg_rdata_o[vpb_pkg::STAT_VME_OWNERSHIP_BIT_ACK]                 <= vme_ownership_bit_ack;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // vme slave channel

  always_comb
  begin
    vs_take = ce_i && vs_req_i && vs_st == VS_IDLE && !vs_ack_o && !vs_err_o;
    vs_bad  = !vpb_pkg::vpb_mode_ok(vs_mode_i);
    vs_post = vs_write_i && vs_posted_i;
    vs_pf   = !vs_write_i && pf_en && vpb_pkg::vpb_is_block(vs_mode_i);
    vs_hit  = !vs_bad && vs_pf && pf_cnt != '0 && vs_addr_i == pf_addr;
    rx_full = rx_cnt == (vpb_pkg::QAW+1)'(vpb_pkg::QDEPTH);
    rx_push = vs_take && !vs_bad && vs_post && !rx_full;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vs_st      <= VS_IDLE;
      vs_ack_o   <= 1'b0;
      vs_err_o   <= 1'b0;
      vs_rdata_o <= '0;
    end
    else if (ce_i)
    begin
      vs_ack_o <= 1'b0;
      vs_err_o <= 1'b0;
      unique case (vs_st)
        VS_IDLE:
          if (vs_take)
          begin
            if (vs_bad)
              vs_err_o <= 1'b1;
            else if (vs_post)
              vs_ack_o <= !rx_full;
            else if (vs_hit)
            begin
              vs_ack_o   <= 1'b1;
              vs_rdata_o <= pfq[pf_rp];
            end
            else if (vs_pf)
              vs_st <= VS_FILL;
            else
              vs_st <= VS_CPL;
          end
        VS_CPL:
          if (pm_end && pm_job == PJ_CPL)
          begin
            vs_ack_o   <= 1'b1;
            vs_rdata_o <= pm_rdata_i;
            vs_st      <= VS_IDLE;
          end
        VS_FILL:
          if (pm_end && pm_job == PJ_FILL)
            vs_st <= VS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rx_push)
    begin
      rx_addr[rx_wp] <= vs_addr_i;
      rx_data[rx_wp] <= vs_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
    end
    else
    begin
      if (rx_push)
        rx_wp <= rx_wp + 1'b1;
      if (rx_pop)
        rx_rp <= rx_rp + 1'b1;
      if (rx_push != rx_pop)
        rx_cnt <= rx_push ? rx_cnt + 1'b1 : rx_cnt - 1'b1;
    end
  end

  assign pf_push = ce_i && pm_req_o && pm_job == PJ_FILL && pm_rvalid_i
                   && pf_cnt != (vpb_pkg::PAW+1)'(vpb_pkg::PF_LEN);

  always_ff @(posedge clock_i)
  begin
    if (pf_push)
      pfq[pf_wp] <= pm_rdata_i;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pf_wp   <= '0;
      pf_rp   <= '0;
      pf_cnt  <= '0;
      pf_addr <= '0;
    end
    else if (vs_take && vs_hit)
    begin
      pf_rp   <= pf_rp + 1'b1;
      pf_cnt  <= pf_cnt - 1'b1;
      pf_addr <= pf_addr + vpb_pkg::PF_STRIDE;
    end
    else if (vs_take)
    begin
      pf_wp   <= '0;
      pf_rp   <= '0;
      pf_cnt  <= '0;
      pf_addr <= vs_addr_i;
    end
    else if (pf_push)
    begin
      pf_wp  <= pf_wp + 1'b1;
      pf_cnt <= pf_cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pci master interface

  assign pm_arb.req_urg = 1'b0;
  assign pm_arb.req_a   = rx_cnt != '0 || vs_st != VS_IDLE || pm_req_o;
  assign pm_arb.req_b   = dma_pm_req_i;
  assign pm_arb.mode    = ctrl[vpb_pkg::CTRL_PM_ARB +: 2];
  assign dma_pm_gnt_o   = pm_arb.gnt_b;
  assign pm_end         = ce_i && pm_req_o && pm_done_i;
  assign rx_pop         = ce_i && !pm_req_o && pm_arb.gnt_a && rx_cnt != '0;

  vpb_arbiter u_pm_arb (
    .clk_i   (clock_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .bus     (pm_arb.arb)
  );

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pm_req_o   <= 1'b0;
      pm_job     <= PJ_POST;
      pm_write_o <= 1'b0;
      pm_burst_o <= 1'b0;
      pm_addr_o  <= '0;
      pm_wdata_o <= '0;
    end
    else if (pm_end)
      pm_req_o <= 1'b0;
    else if (rx_pop)
    begin
      pm_req_o   <= 1'b1;
      pm_job     <= PJ_POST;
      pm_write_o <= 1'b1;
      pm_burst_o <= 1'b0;
      pm_addr_o  <= rx_addr[rx_rp];
      pm_wdata_o <= rx_data[rx_rp];
    end
    else if (ce_i && !pm_req_o && pm_arb.gnt_a && vs_st == VS_CPL)
    begin
      pm_req_o   <= 1'b1;
      pm_job     <= PJ_CPL;
      pm_write_o <= vs_write_i;
      pm_burst_o <= 1'b0;
      pm_addr_o  <= vs_addr_i;
      pm_wdata_o <= vs_wdata_i;
    end
    else if (ce_i && !pm_req_o && pm_arb.gnt_a && vs_st == VS_FILL)
    begin
      pm_req_o   <= 1'b1;
      pm_job     <= PJ_FILL;
      pm_write_o <= 1'b0;
      pm_burst_o <= 1'b1;
      pm_addr_o  <= pf_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pci target channel

  always_comb
  begin
    pt_take = ce_i && pt_req_i && pt_st == PT_IDLE && !pt_ack_o && !pt_err_o;
    pt_bad  = !vpb_pkg::vpb_mode_ok(pt_mode_i);
    pt_post = pt_write_i && pt_posted_i && pt_cycle_i == vpb_pkg::CYC_SINGLE;
    tx_full = tx_cnt == (vpb_pkg::QAW+1)'(vpb_pkg::QDEPTH);
    tx_push = pt_take && !pt_bad && pt_post && !tx_full;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pt_st      <= PT_IDLE;
      pt_ack_o   <= 1'b0;
      pt_err_o   <= 1'b0;
      pt_rdata_o <= '0;
    end
    else if (ce_i)
    begin
      pt_ack_o <= 1'b0;
      pt_err_o <= 1'b0;
      unique case (pt_st)
        PT_IDLE:
          if (pt_take)
          begin
            if (pt_bad)
              pt_err_o <= 1'b1;
            else if (pt_post)
              pt_ack_o <= !tx_full;
            else
              pt_st <= PT_CPL;
          end
        PT_CPL:
          if (vm_end && vm_cpl)
          begin
            pt_ack_o   <= 1'b1;
            pt_rdata_o <= vm_rdata_i;
            pt_st      <= PT_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (tx_push)
    begin
      tx_addr[tx_wp] <= pt_addr_i;
      tx_data[tx_wp] <= pt_wdata_i;
      tx_mode[tx_wp] <= pt_mode_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wp <= tx_wp + 1'b1;
      if (tx_pop)
        tx_rp <= tx_rp + 1'b1;
      if (tx_push != tx_pop)
        tx_cnt <= tx_push ? tx_cnt + 1'b1 : tx_cnt - 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // vme master interface

  assign vm_arb.req_urg = irq_vm_req_i;
  assign vm_arb.req_a   = tx_cnt != '0 || pt_st != PT_IDLE || vm_req_o || vme_ownership_bit;
  assign vm_arb.req_b   = dma_vm_req_i && !vme_ownership_bit;
  assign vm_arb.mode    = ctrl[vpb_pkg::CTRL_VM_ARB +: 2];
  assign irq_vm_gnt_o   = vm_arb.gnt_urg;
  assign dma_vm_gnt_o   = vm_arb.gnt_b;
  assign vm_end         = ce_i && vm_req_o && vm_done_i && !vm_retry_i;
  assign tx_pop         = ce_i && !vm_req_o && vm_arb.gnt_a && tx_cnt != '0;

  vpb_arbiter u_vm_arb (
    .clk_i   (clock_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .bus     (vm_arb.arb)
  );

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      vme_ownership_bit_ack <= 1'b0;
    else if (ce_i)
      vme_ownership_bit_ack <= vme_ownership_bit && vm_arb.gnt_a;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vm_req_o   <= 1'b0;
      vm_cpl     <= 1'b0;
      vm_write_o <= 1'b0;
      vm_cycle_o <= vpb_pkg::CYC_SINGLE;
      vm_mode_o  <= '0;
      vm_addr_o  <= '0;
      vm_wdata_o <= '0;
    end
    else if (vm_end)
      vm_req_o <= 1'b0;
    else if (tx_pop)
    begin
      vm_req_o   <= 1'b1;
      vm_cpl     <= 1'b0;
      vm_write_o <= 1'b1;
      vm_cycle_o <= vpb_pkg::CYC_SINGLE;
      vm_mode_o  <= tx_mode[tx_rp];
      vm_addr_o  <= tx_addr[tx_rp];
      vm_wdata_o <= tx_data[tx_rp];
    end
    else if (ce_i && !vm_req_o && vm_arb.gnt_a && pt_st == PT_CPL)
    begin
      vm_req_o   <= 1'b1;
      vm_cpl     <= 1'b1;
      vm_write_o <= pt_write_i;
      vm_cycle_o <= pt_cycle_i;
      vm_mode_o  <= pt_mode_i;
      vm_addr_o  <= pt_addr_i;
      vm_wdata_o <= pt_wdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  property p_post_ack;
    @(posedge clock_i) disable iff (!rst_n)
      rx_push |=> vs_ack_o && rx_cnt != '0;
  endproperty
  a_post_ack: assert property (p_post_ack) else $error("posted write not acked");

  property p_cpl_ack;
    @(posedge clock_i) disable iff (!rst_n)
      vs_ack_o && $past(vs_st) == VS_CPL |-> $past(pm_done_i) && $past(pm_req_o);
  endproperty
  a_cpl_ack: assert property (p_cpl_ack) else $error("coupled ack before pci end");

  property p_pf_start;
    @(posedge clock_i) disable iff (!rst_n)
      vs_take && vs_pf && !vs_bad && !vs_hit |=> vs_st == VS_FILL;
  endproperty
  a_pf_start: assert property (p_pf_start) else $error("prefetch not started");

  property p_mode_rej;
    @(posedge clock_i) disable iff (!rst_n)
      vs_take && vs_bad |=> vs_err_o && !vs_ack_o && vs_st == VS_IDLE;
  endproperty
  a_mode_rej: assert property (p_mode_rej) else $error("bad mode accepted");

  property p_pm_gnt;
    @(posedge clock_i) disable iff (!rst_n)
      pm_req_o |-> pm_arb.gnt_a && !pm_arb.gnt_b;
  endproperty
  a_pm_gnt: assert property (p_pm_gnt) else $error("pci master without grant");

  property p_vm_gnt;
    @(posedge clock_i) disable iff (!rst_n)
      vm_req_o |-> vm_arb.gnt_a && !vm_arb.gnt_b && !vm_arb.gnt_urg;
  endproperty
  a_vm_gnt: assert property (p_vm_gnt) else $error("vme master without grant");

  property p_retry;
    @(posedge clock_i) disable iff (!rst_n)
      ce_i && vm_req_o && vm_retry_i |=> vm_req_o && $stable(vm_addr_o);
  endproperty
  a_retry: assert property (p_retry) else $error("retry ended the cycle");

  property p_tx_ack;
    @(posedge clock_i) disable iff (!rst_n)
      tx_push |=> pt_ack_o && pt_st == PT_IDLE;
  endproperty
  a_tx_ack: assert property (p_tx_ack) else $error("posted pci write waited");

endmodule : vpb_bridge

// ---- tb/vpb_far_model.sv ----
`timescale 1ns/100ps
module vpb_far_model #(parameter logic [31:0] KEY = 32'h5A5A_0F0F) (
  input wire logic clock_i,
  input wire logic pm_req_i,
  input wire logic pm_burst_i,
  input wire logic [31:0] pm_addr_i,
  input wire logic vm_req_i,
  input wire logic [31:0] vm_addr_i,
  input wire logic [4:0] dly_i,
  input wire logic retry_i,
  output logic pm_rvalid_o,
  output logic [31:0] pm_rdata_o,
  output logic pm_done_o,
  output logic [31:0] vm_rdata_o,
  output logic vm_done_o,
  output logic vm_retry_o
);
  logic [4:0] pc, vc;
  logic rt;
  wire [4:0] pe = dly_i + (pm_burst_i ? 5'd3 : 5'd0);
  wire pb = pm_req_i && !pm_done_o && pc >= dly_i && pc <= pe;
  wire vd = vm_req_i && !vm_done_o && vc == dly_i;
  initial {pc, vc, rt, pm_rvalid_o, pm_done_o, pm_rdata_o, vm_done_o, vm_retry_o, vm_rdata_o} = '0;
  // pci side: beats after dly_i, four on a burst
  always @(posedge clock_i)
  begin
    pc <= pm_req_i && !pm_done_o ? pc + 5'd1 : 5'd0;
    pm_rvalid_o <= pb;
    pm_done_o <= pb && pc == pe;
    pm_rdata_o <= pb ? (pm_addr_i + {25'd0, pc - dly_i, 2'b00}) ^ KEY : ~pm_rdata_o;
  end
  // one retry before the real end
  always @(posedge clock_i)
  begin
    vc <= vm_req_i && !vm_done_o ? vc + 5'd1 : 5'd0;
    vm_done_o <= vd;
    vm_retry_o <= vd && retry_i && !rt;
    rt <= retry_i && vm_req_i && (rt || vd);
    vm_rdata_o <= vd ? vm_addr_i ^ KEY : ~vm_rdata_o;
  end
endmodule : vpb_far_model

// ---- tb/vpb_bridge_tb.sv ----
`timescale 1ns/100ps
module vpb_bridge_tb;
  localparam logic [31:0] KEY = 32'h5A5A_0F0F;
  logic clock_i = 0, reset_n_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, vs_req_i = 0;
  logic vs_write_i = 0, vs_posted_i = 0, pt_req_i = 0, pt_write_i = 0, pt_posted_i = 0;
  logic irq_vm_req_i = 0, dma_vm_req_i = 0, dma_pm_req_i = 0, retry = 0, er, pq, vq;
  logic [3:0] reg_addr_i = 0;
  logic [2:0] vs_mode_i = 0, pt_mode_i = 0, vm_mode_o;
  logic [1:0] pt_cycle_i = 0, vm_cycle_o, cq[$];
  logic [4:0] dly = 1;
  logic [31:0] reg_wdata_i = 0, vs_addr_i = 0, vs_wdata_i = 0, pt_addr_i = 0, pt_wdata_i = 0;
  logic [31:0] reg_rdata_o, vs_rdata_o, pm_addr_o, pm_wdata_o, pt_rdata_o, vm_addr_o;
  logic [31:0] vm_wdata_o, pm_rdata_i, vm_rdata_i, d, a, wd, pmq[$], vmq[$], eq[$];
  logic vs_ack_o, vs_err_o, pm_req_o, pm_write_o, pm_burst_o, pm_rvalid_i, pm_done_i;
  logic pt_ack_o, pt_err_o, vm_req_o, vm_write_o, vm_done_i, vm_retry_i;
  logic irq_vm_gnt_o, dma_vm_gnt_o, dma_pm_gnt_o;
  int miscompares = 0, compares = 0, n;
  vpb_bridge dut_u (.*);
  vpb_far_model #(.KEY(KEY)) far_u (.clock_i, .pm_req_i(pm_req_o), .pm_burst_i(pm_burst_o),
    .pm_addr_i(pm_addr_o), .vm_req_i(vm_req_o), .vm_addr_i(vm_addr_o), .dly_i(dly),
    .retry_i(retry), .pm_rvalid_o(pm_rvalid_i), .pm_rdata_o(pm_rdata_i),
    .pm_done_o(pm_done_i), .vm_rdata_o(vm_rdata_i), .vm_done_o(vm_done_i),
    .vm_retry_o(vm_retry_i));
  function automatic logic [31:0] fx(input logic [31:0] x);
    return x ^ KEY;
  endfunction : fx
  task chk(input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task rd(input logic [3:0] ad);
    reg_addr_i <= ad;
    reg_rd_i <= 1;
    @(posedge clock_i);
    reg_rd_i <= 0;
    @(negedge clock_i);
    d = reg_rdata_o;
    @(posedge clock_i);
  endtask : rd
  task wr(input logic [31:0] v);
    reg_addr_i <= vpb_pkg::REG_CTRL;
    reg_wdata_i <= v;
    reg_wr_i <= 1;
    @(posedge clock_i);
    reg_wr_i <= 0;
  endtask : wr
  // one slave request on either side, cycles to answer in n
  task req(input logic s, w, p, input logic [1:0] c, input logic [2:0] m, input logic [31:0] v);
    if (s) {pt_write_i, pt_posted_i, pt_cycle_i, pt_mode_i, pt_addr_i, pt_wdata_i, pt_req_i}
      <= {w, p, c, m, a, v, 1'b1};
    else {vs_write_i, vs_posted_i, vs_mode_i, vs_addr_i, vs_wdata_i, vs_req_i}
      <= {w, p, m, a, v, 1'b1};
    n = 0;
    do begin @(posedge clock_i); #1 n++; end
    while (!(s ? pt_ack_o | pt_err_o : vs_ack_o | vs_err_o) && n < 300);
    d = s ? pt_rdata_o : vs_rdata_o;
    er = s ? pt_err_o : vs_err_o;
    @(posedge clock_i);
    if (s) pt_req_i <= 0;
    else vs_req_i <= 0;
    @(posedge clock_i);
  endtask : req
  initial forever #5 clock_i = ~clock_i;
  always @(negedge clock_i)
  begin
    if (pm_req_o && !pq && pm_write_o) pmq.push_back(pm_addr_o);
    if (vm_req_o && !vq) begin vmq.push_back(vm_addr_o); cq.push_back(vm_cycle_o); end
    pq = pm_req_o;
    vq = vm_req_o;
  end
  initial
  begin
    #300000;
    miscompares++;
    conclude();
  end
  initial
  begin
    void'($urandom(22));
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1;
    repeat (3) @(posedge clock_i);
    rd(vpb_pkg::REG_CTRL); chk(d, 0);
    rd(4'h8); chk(d, 0);
    wr(32'h0000_0001);
    rd(vpb_pkg::REG_CTRL); chk(d, 32'h0000_0001);
    $display("regs done");
    for (int m = 0; m < 8; m++)
    begin
      a = $urandom & 32'hFFFF_FFFC;
      req(0, 1, 1, 0, m[2:0], $urandom);
      chk({er, n == 1}, {m > 4, 1'b1});
      if (m < 5) eq.push_back(a);
    end
    for (n = 0; n < 200 && pmq.size() < 5; n++) @(posedge clock_i);
    foreach (eq[i]) chk(pmq[i], eq[i]);
    $display("posted done");
    dly <= 12;
    wd = $urandom;
    req(0, 1, 0, 0, 2, wd); chk({er, n > 12}, 1);
    chk(pm_wdata_o, wd);
    dly <= 1;
    a = $urandom & 32'hFFFF_FFF0;
    req(0, 0, 0, 0, vpb_pkg::XM_BLT, 0); chk(d, fx(a));
    a = a + 4;
    req(0, 0, 0, 0, vpb_pkg::XM_MBLT, 0); chk(n, 1);
    chk(d, fx(a));
    $display("prefetch done");
    retry <= 1;
    for (int c = 0; c < 3; c++)
    begin
      a = $urandom;
      req(1, c == 1, 0, c[1:0], 3'($urandom_range(4)), 0); chk(d, fx(a));
      chk(cq[$], c);
    end
    retry <= 0;
    req(1, 0, 0, 0, vpb_pkg::XM_A64, 0); chk(er, 1);
    a = $urandom;
    wd = $urandom;
    req(1, 1, 1, 0, 2, wd); chk(n, 1);
    for (n = 0; n < 200 && vmq.size() < 4; n++) @(posedge clock_i);
    chk(vmq[$], a);
    chk(vm_wdata_o, wd);
    chk({vm_write_o, vm_mode_o}, 4'hA);
    wr(32'h0000_0041);
    repeat (2) @(posedge clock_i);
    rd(vpb_pkg::REG_STAT); chk(d[vpb_pkg::STAT_VME_OWNERSHIP_BIT_ACK], 1);
    wr(32'h0000_0001);
    $display("target done");
    irq_vm_req_i <= 1;
    dma_vm_req_i <= 1;
    dma_pm_req_i <= 1;
    for (n = 0; n < 30 && !(irq_vm_gnt_o | dma_vm_gnt_o); n++) @(negedge clock_i);
    chk({irq_vm_gnt_o, dma_vm_gnt_o}, 2'b10);
    @(posedge clock_i);
    irq_vm_req_i <= 0;
    for (n = 0; n < 30 && !dma_vm_gnt_o; n++) @(negedge clock_i);
    repeat (4) @(negedge clock_i);
    chk({dma_vm_gnt_o, dma_pm_gnt_o}, 2'b11);
    $display("arbiter done");
    conclude();
  end
endmodule : vpb_bridge_tb
